// ---- verilog/sgram_burst_ctrl.sv ----
/*
 * Command decode, burst sequencing and burst termination of a 32-bit
 * synchronous graphics DRAM, two banks. Pins are synchronised, then
 * read/write/block write bursts are driven onto a simple array port.
 * Assumes an array with combinational read on the registered column,
 * and an APB master for the configuration and status registers.
 */
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps

module sgram_burst_ctrl
    import sgram_pkg::*;
#(
    parameter int COL_W = 8
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_b,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // command pins from the memory controller
    input  wire logic               cs_b,
    input  wire logic               ras_b,
    input  wire logic               cas_b,
    input  wire logic               we_b,
    input  wire logic               dsf,
    input  wire logic               bankSel,
    input  wire logic [9:0]         addrPin,
    input  wire logic [3:0]         dqm,
    // data pins, split
    input  wire logic [31:0]        dqIn,
    output logic      [31:0]        dqOut,
    output logic                    dqOe_b,
    // array port
    output logic                    arrRdEn,
    output logic                    arrWrEn,
    output logic                    arrBlkWr,
    output logic                    arrBank,
    output logic      [COL_W-1:0]   arrCol,
    output logic      [31:0]        arrWrData,
    output logic      [3:0]         arrWrMask,
    input  wire logic [31:0]        arrRdData
);
    import sgram_pkg::*;

    // pin synchroniser
    logic [PIN_W-1:0] pinS1_q, pinS2_q;
    logic             sCs_b, sRas_b, sCas_b, sWe_b, sDsf, sBank;
    logic [9:0]       sAddr;
    logic [3:0]       sDqm;
    logic [31:0]      sDq;
    cmd_e             cmd;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pinS1_q <= '1;
            pinS2_q <= '1;
        end else begin
            pinS1_q <= {cs_b, ras_b, cas_b, we_b, dsf, bankSel,
                        addrPin, dqm, dqIn};
            pinS2_q <= pinS1_q;
        end
    end

    assign {sCs_b, sRas_b, sCas_b, sWe_b, sDsf, sBank,
            sAddr, sDqm, sDq} = pinS2_q;

    always_comb begin
        cmd = CMD_NOP;
        if (!sCs_b) begin
            case ({sRas_b, sCas_b, sWe_b})
                3'b011:  cmd = CMD_ACT;
                3'b101:  cmd = CMD_RD;
                3'b100:  cmd = sDsf ? CMD_BW : CMD_WR;
                3'b010:  cmd = CMD_PRE;
                3'b110:  cmd = CMD_HALT;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    // configuration and apb
    logic [3:0]  cfg_q, cfg_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic        cl3, fullPg;
    logic [1:0]  blCode;
    logic [31:0] statWord;

    assign cl3    = cfg_q[CFG_CL3_BIT];
    assign fullPg = cfg_q[CFG_FULL_BIT];
    assign blCode = cfg_q[CFG_BL_LSB +: 2];

    always_comb begin
        cfg_d     = cfg_q;
        prdata_d  = prdata;
        pready_d  = psel && !penable && !pready;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            if (paddr == CFG_OFS) begin
                prdata_d = {28'h0000000, cfg_q};
            end else if (paddr == STAT_OFS) begin
                prdata_d = statWord;
            end else begin
                prdata_d  = 32'h00000000;
                pslverr_d = 1'b1;
            end
        end
        if (psel && penable && pready && pwrite && paddr == CFG_OFS) begin
            cfg_d = pwdata[3:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q   <= CFG_RST;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // bank open flags and precharge timers
    logic [1:0] open_q, open_d;
    logic [1:0] preCnt_q [2];
    logic [1:0] preCnt_d [2];
    logic [1:0] preBusy;

    always_comb begin
        open_d   = open_q;
        preCnt_d = preCnt_q;
        for (int b = 0; b < 2; b++) begin
            if (preCnt_q[b] != 2'd0) begin
                preCnt_d[b] = preCnt_q[b] - 2'd1;
            end
            preBusy[b] = (preCnt_q[b] != 2'd0);
        end
        // reopen only after the precharge time
        if (cmd == CMD_ACT && !preBusy[sBank]) begin
            open_d[sBank] = 1'b1;
        end
        if (cmd == CMD_PRE) begin
            open_d[sBank]   = 1'b0;
            preCnt_d[sBank] = 2'(PRECHARGE_CYC - 1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            open_q   <= 2'b00;
            preCnt_q <= '{2'd0, 2'd0};
        end else begin
            open_q   <= open_d;
            preCnt_q <= preCnt_d;
        end
    end

    // burst sequencer
    burst_e           st_q, st_d;
    logic [8:0]       cnt_q, cnt_d;
    logic [COL_W-1:0] col_q, col_d;
    logic             bk_q, bk_d, full_q, full_d;
    logic             rdEn_d, wrEn_d, blk_d, bankOut_d, cont;
    logic [COL_W-1:0] colOut_d;
    logic [31:0]      wrData_d;
    logic [3:0]       mask_d;
    logic [8:0]       len;
    logic             tgtOpen, fullRd;

    assign len     = fullPg ? 9'(FULL_PAGE_LEN) : 9'(1 << blCode);
    assign tgtOpen = open_q[sBank];
    assign fullRd  = (st_q == ST_READ) && full_q;
    assign statWord = {26'h0, preBusy, open_q,
                       st_q == ST_WRITE, st_q == ST_READ};

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        col_d     = col_q;
        bk_d      = bk_q;
        full_d    = full_q;
        rdEn_d    = 1'b0;
        wrEn_d    = 1'b0;
        blk_d     = 1'b0;
        bankOut_d = arrBank;
        colOut_d  = arrCol;
        wrData_d  = arrWrData;
        mask_d    = arrWrMask;
        cont      = 1'b1;
        case (cmd)
            CMD_RD: begin
                if (tgtOpen) begin
                    cont      = 1'b0;
                    rdEn_d    = 1'b1;
                    bankOut_d = sBank;
                    colOut_d  = sAddr[COL_W-1:0];
                    col_d     = sAddr[COL_W-1:0] + 1'b1;
                    bk_d      = sBank;
                    full_d    = fullPg;
                    cnt_d     = len - 9'd1;
                    st_d      = (len == 9'd1) ? ST_IDLE : ST_READ;
                end
            end
            CMD_WR, CMD_BW: begin
                if (tgtOpen && !fullRd) begin
                    // fresh burst starts with this word
                    cont      = 1'b0;
                    bankOut_d = sBank;
                    colOut_d  = sAddr[COL_W-1:0];
                    wrData_d  = sDq;
                    mask_d    = sDqm;
                    bk_d      = sBank;
                    full_d    = fullPg;
                    if (cmd == CMD_BW) begin
                        blk_d = 1'b1;
                        st_d  = ST_IDLE;
                    end else begin
                        wrEn_d = 1'b1;
                        col_d  = sAddr[COL_W-1:0] + 1'b1;
                        cnt_d  = len - 9'd1;
                        st_d   = (len == 9'd1) ? ST_IDLE : ST_WRITE;
                    end
                end
            end
            CMD_PRE: begin
                // precharge ends the burst on its bank
                if (sBank == bk_q && st_q != ST_IDLE) begin
                    cont = 1'b0;
                    st_d = ST_IDLE;
                end
            end
            CMD_HALT: begin
                // halt acts only on a full page burst
                if (full_q && st_q != ST_IDLE) begin
                    cont = 1'b0;
                    st_d = ST_IDLE;
                end
            end
            default: begin
            end
        endcase
        if (cont && st_q != ST_IDLE) begin
            bankOut_d = bk_q;
            colOut_d  = col_q;
            // sequential order wraps inside the row
            col_d     = col_q + 1'b1;
            if (st_q == ST_READ) begin
                rdEn_d = 1'b1;
            end else begin
                wrEn_d   = 1'b1;
                wrData_d = sDq;
                mask_d   = sDqm;
            end
            if (!full_q) begin
                cnt_d = cnt_q - 9'd1;
                if (cnt_q == 9'd1) begin
                    st_d = ST_IDLE;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q      <= ST_IDLE;
            cnt_q     <= 9'd0;
            col_q     <= '0;
            bk_q      <= 1'b0;
            full_q    <= 1'b0;
            arrRdEn   <= 1'b0;
            arrWrEn   <= 1'b0;
            arrBlkWr  <= 1'b0;
            arrBank   <= 1'b0;
            arrCol    <= '0;
            arrWrData <= 32'h00000000;
            arrWrMask <= 4'h0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            col_q     <= col_d;
            bk_q      <= bk_d;
            full_q    <= full_d;
            arrRdEn   <= rdEn_d;
            arrWrEn   <= wrEn_d;
            arrBlkWr  <= blk_d;
            arrBank   <= bankOut_d;
            arrCol    <= colOut_d;
            arrWrData <= wrData_d;
            arrWrMask <= mask_d;
        end
    end

    // read data pipe; fetched words drain, none follow
    logic        p0V_q, p1V_q, p0V_d, p1V_d;
    logic [31:0] p0D_q, p1D_q, p0D_d, p1D_d, dqOut_d;
    logic [3:0]  dm0_q, dm1_q;
    logic        dqOe_d, outV;
    logic [3:0]  outDm;

    always_comb begin
        p0V_d   = arrRdEn;
        p0D_d   = arrRdEn ? arrRdData : p0D_q;
        p1V_d   = p0V_q;
        p1D_d   = p0D_q;
        outV    = cl3 ? p1V_q : p0V_q;
        outDm   = cl3 ? dm1_q : dm0_q;
        dqOut_d = cl3 ? p1D_q : p0D_q;
        dqOe_d  = !(outV && outDm != 4'hf);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p0V_q  <= 1'b0;
            p1V_q  <= 1'b0;
            p0D_q  <= 32'h00000000;
            p1D_q  <= 32'h00000000;
            dm0_q  <= 4'hf;
            dm1_q  <= 4'hf;
            dqOut  <= 32'h00000000;
            dqOe_b <= 1'b1;
        end else begin
            p0V_q  <= p0V_d;
            p1V_q  <= p1V_d;
            p0D_q  <= p0D_d;
            p1D_q  <= p1D_d;
            dm0_q  <= sDqm;
            dm1_q  <= dm0_q;
            dqOut  <= dqOut_d;
            dqOe_b <= dqOe_d;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_read_abort: assert property (
        cmd == CMD_RD && tgtOpen |=> arrRdEn
            && arrCol == $past(sAddr[COL_W-1:0]))
        else $error("read did not restart at new column");
    a_write_first: assert property (
        cmd == CMD_WR && tgtOpen && !fullRd |=> arrWrEn
            && arrWrData == $past(sDq))
        else $error("write burst did not start with its data");
    a_write_cut: assert property (
        cmd == CMD_RD && st_q == ST_WRITE |=> !arrWrEn)
        else $error("write data stored after read command");
    a_full_keep: assert property (
        cmd == CMD_WR && fullRd |=> arrRdEn && st_q == ST_READ)
        else $error("full page read was interrupted by write");
    a_halt_nop: assert property (
        cmd == CMD_HALT && st_q == ST_READ && !full_q && cnt_q > 9'd1
            |=> arrRdEn)
        else $error("halt acted outside full page mode");
    a_halt_float: assert property (
        (!arrRdEn)[*3] |=> dqOe_b)
        else $error("bus still driven after read drained");
    a_halt_wr: assert property (
        cmd == CMD_HALT && full_q && st_q == ST_WRITE |=> !arrWrEn)
        else $error("full page write stored in halt clock");
    a_pre_end: assert property (
        cmd == CMD_PRE && sBank == bk_q && st_q != ST_IDLE
            |=> st_q == ST_IDLE ##1 !arrRdEn && !arrWrEn)
        else $error("precharge did not end burst");
    a_pre_wait: assert property (
        cmd == CMD_PRE |=> !open_q[$past(sBank)]
            ##1 !open_q[$past(sBank, 2)] ##1 !open_q[$past(sBank, 3)])
        else $error("bank reopened before precharge time");

    c_full_halt: cover property (cmd == CMD_HALT && fullRd);
    c_rd_rd: cover property (cmd == CMD_RD ##1 cmd == CMD_RD);
    c_wr_pre: cover property (st_q == ST_WRITE && cmd == CMD_PRE);

endmodule : sgram_burst_ctrl

// ---- verilog/sgram_pkg.sv ----
/*
 * Shared constants for the graphics DRAM command interval and burst
 * termination block: register map, field positions, reset values,
 * timing counts and the command and burst state enumerations.
 * Assumes a 100 MHz system clock.
 */
package sgram_pkg;

    // clock and timing
    localparam int PERIOD_NS           = 10;
    localparam int PRECHARGE_TIME_NS   = 30;
    localparam int PRECHARGE_CYC       =
        (PRECHARGE_TIME_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int FULL_PAGE_LEN       = 256;
    localparam int PIN_W               = 52;

    // register byte offsets
    localparam logic [7:0] CFG_OFS     = 8'h00;
    localparam logic [7:0] STAT_OFS    = 8'h04;

    // configuration fields and reset value
    localparam int CFG_CL3_BIT         = 0;
    localparam int CFG_FULL_BIT        = 1;
    localparam int CFG_BL_LSB          = 2;
    localparam logic [3:0] CFG_RST     = 4'h8;

    // status fields
    localparam int STAT_RD_BIT         = 0;
    localparam int STAT_WR_BIT         = 1;
    localparam int STAT_OPEN_LSB       = 2;
    localparam int STAT_PRE_LSB        = 4;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BW, CMD_PRE, CMD_HALT
    } cmd_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11
    } burst_e;

endpackage : sgram_pkg

// ---- verification/sgram_ctrl_model.sv ----
/*
 * Memory controller model: drives the command, mask and write data
 * pins of the graphics DRAM block, one command per clock.
 * Assumes the caller keeps command spacing legal for the scenario.
 */
`timescale 1ns/10ps

module sgram_ctrl_model
    import sgram_pkg::*;
(
    // clock
    input  wire logic        mclk,
    // command pins
    output logic             cs_b,
    output logic             ras_b,
    output logic             cas_b,
    output logic             we_b,
    output logic             dsf,
    output logic             bankSel,
    output logic [9:0]       addrPin,
    // mask and data pins
    output logic [3:0]       dqm,
    output logic [31:0]      dqIn
);
    // pins idle until the first command
    initial begin
        {cs_b, ras_b, cas_b, we_b, dsf} = 5'b11110;
        bankSel = 1'b0;
        addrPin = 10'h000;
        dqm = 4'h0;
        dqIn = 32'h0;
    end

    task automatic send(input cmd_e c, input logic [7:0] col,
                        input logic [31:0] d, input logic [3:0] m);
        @(posedge mclk);
        case (c)
            CMD_ACT:  {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b00110;
            CMD_RD:   {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b01010;
            CMD_WR:   {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b01000;
            CMD_BW:   {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b01001;
            CMD_PRE:  {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b00100;
            CMD_HALT: {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b01100;
            default:  {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b11110;
        endcase
        addrPin <= {2'b00, col};
        dqIn <= d;
        dqm <= m;
    endtask : send

    // released bus shows inverted last value
    task automatic idle(input int n, input logic [3:0] m);
        repeat (n) begin
            @(posedge mclk);
            {cs_b, ras_b, cas_b, we_b, dsf} <= 5'b11110;
            dqIn <= ~dqIn;
            dqm <= m;
        end
    endtask : idle

endmodule : sgram_ctrl_model

// ---- verification/sgram_burst_ctrl_test.sv ----
/*
 * Self-checking bench for the burst control block: APB register
 * access, burst lengths and latencies, aborts and terminations.
 * Assumes a combinational array model built from bank and column.
 */
`timescale 1ns/10ps

module sgram_burst_ctrl_test;
    import sgram_pkg::*;

    typedef struct packed {logic [3:0] cfg; int words; int lat;} row_s;

    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, dqIn, dqOut, arrWrData, arrRdData, rdat;
    logic        pready, pslverr, cs_b, ras_b, cas_b, we_b, dsf;
    logic        bankSel, dqOe_b, arrRdEn, arrWrEn, arrBlkWr, arrBank;
    logic        err;
    logic [9:0]  addrPin;
    logic [3:0]  dqm, arrWrMask;
    logic [7:0]  arrCol;
    logic [31:0] rdQ[$];
    logic [39:0] wrQ[$];
    int          cyc = 0, rdCyc = 0, firstCyc = 0, nBlk = 0;
    int          numErrors = 0, nTests = 0;
    row_s        rows[8] = '{'{4'h0, 1, 5}, '{4'h1, 1, 6}, '{4'h4, 2, 5},
        '{4'h5, 2, 6}, '{4'h8, 4, 5}, '{4'h9, 4, 6}, '{4'hc, 8, 5},
        '{4'hd, 8, 6}};

    always #5 mclk = ~mclk;
    assign arrRdData = {8'hca, 15'h0, arrBank, arrCol};

    sgram_burst_ctrl i_sgram_burst_ctrl (.mclk(mclk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
        .we_b(we_b), .dsf(dsf), .bankSel(bankSel), .addrPin(addrPin),
        .dqm(dqm), .dqIn(dqIn), .dqOut(dqOut), .dqOe_b(dqOe_b),
        .arrRdEn(arrRdEn), .arrWrEn(arrWrEn), .arrBlkWr(arrBlkWr),
        .arrBank(arrBank), .arrCol(arrCol), .arrWrData(arrWrData),
        .arrWrMask(arrWrMask), .arrRdData(arrRdData));

    sgram_ctrl_model i_sgram_ctrl_model (.mclk(mclk), .cs_b(cs_b),
        .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .dsf(dsf),
        .bankSel(bankSel), .addrPin(addrPin), .dqm(dqm), .dqIn(dqIn));

    // records driven words, array writes not fully masked and block writes
    always @(negedge mclk) begin
        if (!cs_b && ras_b && !cas_b && we_b)
            rdCyc = cyc;
        if (dqOe_b === 1'b0) begin
            if (rdQ.size() == 0)
                firstCyc = cyc;
            rdQ.push_back(dqOut);
        end
        if (arrWrEn === 1'b1 && arrWrMask !== 4'hf)
            wrQ.push_back({arrCol, arrWrData});
        if (arrBlkWr === 1'b1)
            nBlk++;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc >= 20000) begin
            numErrors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [39:0] e, g);
        nTests++;
        if (g !== e) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] pat(input logic [7:0] c);
        return {8'hca, 15'h0, 1'b0, c};
    endfunction : pat

    task automatic go(input cmd_e c, input logic [7:0] col,
                      input logic [31:0] d = 32'h0);
        i_sgram_ctrl_model.send(c, col, d, 4'h0);
    endtask : go

    task automatic idle(input int n);
        i_sgram_ctrl_model.idle(n, 4'h0);
    endtask : idle

    task automatic setup(input logic [3:0] c, input logic act);
        apb(1'b1, CFG_OFS, {28'h0, c}, rdat, err);
        idle(2);
        if (act) begin
            go(CMD_ACT, 8'h00);
            idle(6);
        end
        rdQ.delete();
        wrQ.delete();
        nBlk = 0;
    endtask : setup

    task automatic words(input logic [7:0] c0, input int n);
        check("word count", n, rdQ.size());
        foreach (rdQ[k])
            check("read word", pat(8'(c0 + k)), rdQ[k]);
    endtask : words

    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, CFG_OFS, 32'h0, rdat, err);
        check("cfg reset", {28'h0, CFG_RST}, rdat);
        apb(1'b1, STAT_OFS, 32'hff, rdat, err);
        check("status write err", 32'h0, {31'h0, err});
        apb(1'b0, STAT_OFS, 32'h0, rdat, err);
        check("status idle", 32'h0, rdat);
        apb(1'b0, 8'h08, 32'h0, rdat, err);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rdat);
        repeat (10001) @(posedge mclk);
        foreach (rows[i]) begin
            setup(rows[i].cfg, 1'b1);
            go(CMD_RD, 8'h10);
            idle(16);
            check("latency", rows[i].lat, firstCyc - rdCyc);
            words(8'h10, rows[i].words);
            go(CMD_PRE, 8'h00);
            idle(4);
        end
        // full page read ignores write, halts after five words
        setup(4'h2, 1'b1);
        go(CMD_RD, 8'hfe);
        idle(2);
        go(CMD_WR, 8'h80, 32'h0bad_0bad);
        idle(1);
        go(CMD_HALT, 8'h00);
        idle(12);
        words(8'hfe, 5);
        check("write in full read", 32'h0, wrQ.size());
        setup(4'h2, 1'b0);
        go(CMD_WR, 8'hfe, 32'h1111_0000);
        go(CMD_NOP, 8'h00, 32'h2222_0000);
        go(CMD_HALT, 8'h00, 32'h3333_0000);
        idle(8);
        check("halt write count", 32'h2, wrQ.size());
        check("halt write 0", {8'hfe, 32'h1111_0000}, wrQ[0]);
        check("halt write 1", {8'hff, 32'h2222_0000}, wrQ[1]);
        setup(4'h8, 1'b0);
        go(CMD_RD, 8'h10);
        go(CMD_HALT, 8'h00);
        idle(12);
        words(8'h10, 4);
        setup(4'h8, 1'b0);
        go(CMD_RD, 8'h20);
        go(CMD_RD, 8'h3f);
        idle(12);
        check("abort first", pat(8'h20), rdQ.pop_front());
        words(8'h3f, 4);
        setup(4'h8, 1'b0);
        go(CMD_WR, 8'h30, 32'haaaa_0001);
        go(CMD_WR, 8'h50, 32'hbbbb_0002);
        go(CMD_NOP, 8'h00, 32'hcccc_0003);
        go(CMD_RD, 8'h60, 32'hdddd_0004);
        idle(12);
        check("wr count", 32'h3, wrQ.size());
        check("wr 0", {8'h30, 32'haaaa_0001}, wrQ[0]);
        check("wr 1", {8'h50, 32'hbbbb_0002}, wrQ[1]);
        check("wr 2", {8'h51, 32'hcccc_0003}, wrQ[2]);
        setup(4'h8, 1'b0);
        i_sgram_ctrl_model.send(CMD_RD, 8'h10, 32'h0, 4'hf);
        i_sgram_ctrl_model.idle(10, 4'hf);
        idle(2);
        check("masked words", 32'h0, rdQ.size());
        go(CMD_BW, 8'h08);
        idle(4);
        check("block write", 32'h1, nBlk);
        check("block no word", 32'h0, wrQ.size());
        go(CMD_WR, 8'h40, 32'h4444_0001);
        i_sgram_ctrl_model.send(CMD_PRE, 8'h00, 32'h5555_0002, 4'hf);
        idle(8);
        check("pre write count", 32'h1, wrQ.size());
        check("pre write", {8'h40, 32'h4444_0001}, wrQ[0]);
        // precharge ends read; early activate refused
        setup(4'hc, 1'b1);
        go(CMD_RD, 8'h20);
        idle(1);
        go(CMD_PRE, 8'h00);
        go(CMD_ACT, 8'h00);
        idle(12);
        check("pre read min", 32'h1, rdQ.size() >= 2);
        words(8'h20, 2);
        setup(4'hc, 1'b0);
        go(CMD_RD, 8'h20);
        idle(14);
        check("closed bank read", 32'h0, rdQ.size());
        setup(4'hc, 1'b1);
        go(CMD_RD, 8'h20);
        idle(14);
        words(8'h20, 8);
        // latency three: masked read turnaround, masked write precharge
        setup(4'h9, 1'b0);
        go(CMD_RD, 8'h10);
        idle(1);
        i_sgram_ctrl_model.idle(3, 4'hf);
        go(CMD_WR, 8'h40, 32'h7777_0001);
        i_sgram_ctrl_model.send(CMD_NOP, 8'h00, 32'h8888_0002, 4'hf);
        i_sgram_ctrl_model.send(CMD_PRE, 8'h00, 32'h9999_0003, 4'hf);
        idle(10);
        check("cl3 latency", 32'd6, firstCyc - rdCyc);
        words(8'h10, 1);
        check("cl3 wr count", 32'h1, wrQ.size());
        check("cl3 wr", {8'h40, 32'h7777_0001}, wrQ[0]);
        summarize();
    end

endmodule : sgram_burst_ctrl_test
